// ==== inc/spd_defs.vh ====
// Constants for the strap pin mode decoder: levels, register map, fields, reset values and counts
`ifndef SPD_DEFS_VH
`define SPD_DEFS_VH

// Decoded three-level strap states
`define SPD_LVL_LOW 2'h0
`define SPD_LVL_HIGH 2'h1
`define SPD_LVL_MID 2'h2

// Register byte offsets
`define SPD_OFS_CTRL 4'h0
`define SPD_OFS_STATUS 4'h4
`define SPD_OFS_CAL_CNT 4'h8

// Control register fields
`define SPD_CTRL_FS_ADJ_LSB 0
`define SPD_CTRL_FS_ADJ_W 9
`define SPD_CTRL_RESET 32'h00000100

// Status register fields
`define SPD_ST_SHARED_LSB 0
`define SPD_ST_CALPIN_LSB 2
`define SPD_ST_RSTSEL_LSB 4
`define SPD_ST_ECE_LSB 6
`define SPD_ST_EXT_CTRL 8
`define SPD_ST_FS_HIGH 9
`define SPD_ST_DIFF_RST 10
`define SPD_ST_DUAL_EDGE 11
`define SPD_ST_CAL_DLY 12
`define SPD_ST_SER_EN 13
`define SPD_ST_CAL_DONE 14

// Full-scale codes used when the range comes from the pin
`define SPD_FS_CODE_LOW 9'h000
`define SPD_FS_CODE_HIGH 9'h1FF

// Cycles after reset release before straps are taken for the power-up decode
`define SPD_SETTLE_CYCLES 4'h4

// AXI responses
`define SPD_RESP_OKAY 2'h0
`define SPD_RESP_SLVERR 2'h2

`endif

// ==== testbench/spd_strap_decoder_asserts.sv ====
// Port assertions for the strap pin mode decoder
`timescale 1ns/1ps
module spd_strap_decoder_asserts (
	input wire CORE_CLK,
	input wire NRST,
	input wire SAMPLE_CLK_P,
	input wire FULL_SCALE_SELECT,
	input wire [8:0] FULL_SCALE_CODE,
	input wire EXT_CTRL_ACTIVE,
	input wire ALTERNATE_EXT_CTRL_ENABLE,
	input wire OUT_CLOCK_RESET_DIFF_SELECT,
	input wire OUT_CLOCK_RESET_NEG,
	input wire SERIAL_CHIP_SELECT_N,
	input wire SERIAL_IF_ENABLE,
	input wire DUAL_EDGE_SAMPLING,
	input wire I_SAMPLE,
	input wire Q_SAMPLE,
	input wire CAL_START
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);
	sequence s_clk_fall;
		$fell(SAMPLE_CLK_P);
	endsequence
	sequence s_i_pulse;
		I_SAMPLE ##1 !I_SAMPLE;
	endsequence
	a_fall_strobe: assert property (s_clk_fall |-> ##[1:5] s_i_pulse)
		else $error("no I strobe after clock fall");
	// Three cycles of margin let a strobe already in the pipe drain on a mode change
	a_dual_no_q: assert property (DUAL_EDGE_SAMPLING [*3] |-> !Q_SAMPLE)
		else $error("Q strobe in dual edge mode");
	a_diff_high: assert property (OUT_CLOCK_RESET_DIFF_SELECT |-> FULL_SCALE_SELECT)
		else $error("reduced range in differential reset mode");
	a_neg_diff: assert property (OUT_CLOCK_RESET_NEG |-> OUT_CLOCK_RESET_DIFF_SELECT)
		else $error("reset negative outside differential mode");
	a_alt_role: assert property (ALTERNATE_EXT_CTRL_ENABLE |-> !OUT_CLOCK_RESET_DIFF_SELECT)
		else $error("alternate enable in differential mode");
	a_pin_code: assert property (!EXT_CTRL_ACTIVE |->
		FULL_SCALE_CODE == (FULL_SCALE_SELECT ? 9'h1FF : 9'h000))
		else $error("range code not from pin");
	a_cs_serial: assert property (!SERIAL_CHIP_SELECT_N |-> SERIAL_IF_ENABLE)
		else $error("chip select without serial enable");
	a_cal_once: assert property (CAL_START |=> !CAL_START [*8])
		else $error("calibration start repeated");
endmodule // spd_strap_decoder_asserts
bind spd_strap_decoder spd_strap_decoder_asserts u_spd_strap_decoder_asserts (.CORE_CLK(CORE_CLK), .NRST(NRST),
	.SAMPLE_CLK_P(SAMPLE_CLK_P), .FULL_SCALE_SELECT(FULL_SCALE_SELECT), .FULL_SCALE_CODE(FULL_SCALE_CODE),
	.EXT_CTRL_ACTIVE(EXT_CTRL_ACTIVE), .ALTERNATE_EXT_CTRL_ENABLE(ALTERNATE_EXT_CTRL_ENABLE),
	.OUT_CLOCK_RESET_DIFF_SELECT(OUT_CLOCK_RESET_DIFF_SELECT), .OUT_CLOCK_RESET_NEG(OUT_CLOCK_RESET_NEG),
	.SERIAL_CHIP_SELECT_N(SERIAL_CHIP_SELECT_N), .SERIAL_IF_ENABLE(SERIAL_IF_ENABLE),
	.DUAL_EDGE_SAMPLING(DUAL_EDGE_SAMPLING), .I_SAMPLE(I_SAMPLE), .Q_SAMPLE(Q_SAMPLE), .CAL_START(CAL_START));

// ==== testbench/spd_strap_model.sv ====
// Board straps and input clock source for the decoder pins
`timescale 1ns/1ps
`include "spd_defs.vh"
module spd_strap_model (
	input wire clk,
	input wire [7:0] lvl,
	input wire mid_hi,
	input wire run,
	output reg [3:0] above_hi,
	output reg [3:0] below_lo,
	output reg sclk
);
	integer i;
	reg [1:0] cnt_q = 2'h0;
	initial sclk = 1'b0;
	// Levels move only on request, so straps hold through power-up
	always @* begin
		for (i = 0; i < 4; i = i + 1) begin
			above_hi[i] = lvl[2*i+:2] == `SPD_LVL_HIGH || (lvl[2*i+:2] == `SPD_LVL_MID && mid_hi);
			below_lo[i] = lvl[2*i+:2] == `SPD_LVL_LOW || (lvl[2*i+:2] == `SPD_LVL_MID && mid_hi);
		end
	end
	// Three core cycles a phase; stands low while stopped
	always @(posedge clk) begin
		cnt_q <= (cnt_q == 2'h2 || !run) ? 2'h0 : cnt_q + 2'h1;
		if (!run)
			sclk <= 1'b0;
		else if (cnt_q == 2'h2)
			sclk <= ~sclk;
	end
endmodule // spd_strap_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the strap pin mode decoder
`timescale 1ns/1ps
`include "spd_defs.vh"
module testbench;
	reg CORE_CLK = 1'b0;
	reg NRST = 1'b0;
	reg [7:0] lvl = 8'h55;
	reg mid_hi = 1'b0;
	reg run = 1'b0;
	reg [3:0] S_AXI_AWADDR = 4'h0;
	reg [3:0] S_AXI_ARADDR = 4'h0;
	reg [31:0] S_AXI_WDATA = 32'h0;
	reg [3:0] S_AXI_WSTRB = 4'h0;
	reg S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
	wire [3:0] ah, bl;
	wire [8:0] FULL_SCALE_CODE;
	wire [31:0] S_AXI_RDATA;
	wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
	wire FULL_SCALE_SELECT, EXT_CTRL_ACTIVE, ALTERNATE_EXT_CTRL_ENABLE, OUT_CLOCK_RESET_DIFF_SELECT;
	wire OUT_CLOCK_RESET_NEG, CAL_DELAY_SELECT, SERIAL_CHIP_SELECT_N, SERIAL_IF_ENABLE, DUAL_EDGE_SAMPLING;
	wire SAMPLE_CLK_P, I_SAMPLE, Q_SAMPLE, CAL_START, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	wire S_AXI_ARREADY, S_AXI_RVALID;
	wire [5:0] mode_w = {EXT_CTRL_ACTIVE, OUT_CLOCK_RESET_DIFF_SELECT, OUT_CLOCK_RESET_NEG, SERIAL_IF_ENABLE,
		DUAL_EDGE_SAMPLING, SERIAL_CHIP_SELECT_N};
	integer err_count = 0, samples_checked = 0, cyc = 0, s, c, r, e, n, i_n;
	reg [31:0] v, d;
	reg [1:0] rsp;
	reg [6:0] x;
	reg pa, pw, ta, tw, tb;
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	spd_strap_model u_spd_strap_model (.clk(CORE_CLK), .lvl(lvl), .mid_hi(mid_hi), .run(run),
		.above_hi(ah), .below_lo(bl), .sclk(SAMPLE_CLK_P));
	spd_strap_decoder #(.CAL_DLY_SHORT(32'd4), .CAL_DLY_LONG(32'd8)) u_spd_strap_decoder (.CORE_CLK(CORE_CLK),
		.NRST(NRST), .SAMPLE_CLK_P(SAMPLE_CLK_P), .FULL_SCALE_SELECT(FULL_SCALE_SELECT),
		.FULL_SCALE_CODE(FULL_SCALE_CODE), .EXT_CTRL_ACTIVE(EXT_CTRL_ACTIVE),
		.ALTERNATE_EXT_CTRL_ENABLE(ALTERNATE_EXT_CTRL_ENABLE),
		.OUT_CLOCK_RESET_DIFF_SELECT(OUT_CLOCK_RESET_DIFF_SELECT), .OUT_CLOCK_RESET_NEG(OUT_CLOCK_RESET_NEG),
		.CAL_DELAY_SELECT(CAL_DELAY_SELECT), .SERIAL_CHIP_SELECT_N(SERIAL_CHIP_SELECT_N),
		.SERIAL_IF_ENABLE(SERIAL_IF_ENABLE), .DUAL_EDGE_SAMPLING(DUAL_EDGE_SAMPLING),
		.I_SAMPLE(I_SAMPLE), .Q_SAMPLE(Q_SAMPLE), .CAL_START(CAL_START),
		.S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
		.SHARED_ABOVE_HI(ah[0]), .SHARED_BELOW_LO(bl[0]), .CAL_PIN_ABOVE_HI(ah[1]), .CAL_PIN_BELOW_LO(bl[1]),
		.RST_SEL_ABOVE_HI(ah[2]), .RST_SEL_BELOW_LO(bl[2]), .ECE_PIN_ABOVE_HI(ah[3]), .ECE_PIN_BELOW_LO(bl[3]));
	task chk(input [31:0] g, input [31:0] ex);
		begin
			samples_checked = samples_checked + 1;
			if (g !== ex) begin
				err_count = err_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, ex);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks=%0d errors=%0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	always @(posedge CORE_CLK) begin
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_count = err_count + 1;
			give_verdict;
		end
	end
	// Ready is only sampled off-edge; the slave state moves on rising edges alone
	task wr(input [3:0] a, input [31:0] dt, input [3:0] sb);
		begin
			@(posedge CORE_CLK);
			S_AXI_AWADDR <= a;
			S_AXI_WDATA <= dt;
			S_AXI_WSTRB <= sb;
			S_AXI_AWVALID <= 1'b1;
			S_AXI_WVALID <= 1'b1;
			S_AXI_BREADY <= 1'b1;
			pa = 1'b1;
			pw = 1'b1;
			tb = 1'b0;
			while (pa || pw) begin
				@(negedge CORE_CLK);
				ta = pa && S_AXI_AWREADY === 1'b1;
				tw = pw && S_AXI_WREADY === 1'b1;
				@(posedge CORE_CLK);
				if (ta)
					S_AXI_AWVALID <= 1'b0;
				if (tw)
					S_AXI_WVALID <= 1'b0;
				pa = pa && !ta;
				pw = pw && !tw;
			end
			while (!tb) begin
				@(negedge CORE_CLK);
				tb = S_AXI_BVALID === 1'b1;
				rsp = S_AXI_BRESP;
				@(posedge CORE_CLK);
			end
			S_AXI_BREADY <= 1'b0;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge CORE_CLK);
			S_AXI_ARADDR <= a;
			S_AXI_ARVALID <= 1'b1;
			S_AXI_RREADY <= 1'b1;
			ta = 1'b0;
			tb = 1'b0;
			while (!tb) begin
				@(negedge CORE_CLK);
				tb = S_AXI_RVALID === 1'b1;
				d = S_AXI_RDATA;
				rsp = S_AXI_RRESP;
				ta = ta || S_AXI_ARREADY === 1'b1;
				@(posedge CORE_CLK);
				if (ta)
					S_AXI_ARVALID <= 1'b0;
			end
			S_AXI_RREADY <= 1'b0;
		end
	endtask
	task strap(input [7:0] l);
		begin
			@(posedge CORE_CLK);
			v = $urandom;
			lvl <= l;
			mid_hi <= v[0];
			repeat (7) @(posedge CORE_CLK);
			@(negedge CORE_CLK);
		end
	endtask
	task cal_run(input [7:0] l, input lng);
		begin
			@(posedge CORE_CLK);
			NRST <= 1'b0;
			run <= 1'b0;
			lvl <= l;
			repeat (4) @(posedge CORE_CLK);
			@(negedge CORE_CLK);
			chk({FULL_SCALE_SELECT, FULL_SCALE_CODE, CAL_DELAY_SELECT, SERIAL_CHIP_SELECT_N, CAL_START}, 13'h1FFA);
			@(posedge CORE_CLK);
			NRST <= 1'b1;
			repeat (3) @(posedge CORE_CLK);
			run <= 1'b1;
			n = 0;
			i_n = 0;
			while (CAL_START !== 1'b1 && i_n < 300) begin
				@(negedge CORE_CLK);
				n = n + Q_SAMPLE;
				i_n = i_n + 1;
			end
			chk(CAL_DELAY_SELECT, lng);
			chk(n >= (lng ? 7 : 3) && n <= (lng ? 9 : 5), 1);
		end
	endtask
	task count(input dual);
		begin
			n = 0;
			i_n = 0;
			repeat (60) begin
				@(negedge CORE_CLK);
				i_n = i_n + I_SAMPLE;
				n = n + Q_SAMPLE;
			end
			chk(dual ? n == 0 && i_n >= 18 && i_n <= 22 : n >= 8 && n <= 12 && i_n == n, 1);
		end
	endtask
	// Bits: range high, extended, diff reset, reset negative, serial enable, dual edge, chip select
	function [6:0] exp_mode(input [1:0] sh, input [1:0] cl, input [1:0] rs, input [1:0] ec);
		reg df;
		begin
			df = rs == `SPD_LVL_LOW;
			exp_mode = {df || sh != `SPD_LVL_LOW,
				ec == `SPD_LVL_LOW || (ec == `SPD_LVL_MID && !df && sh == `SPD_LVL_MID), df, df && sh == `SPD_LVL_HIGH,
				sh == `SPD_LVL_MID, cl == `SPD_LVL_MID, !(sh == `SPD_LVL_MID && cl == `SPD_LVL_LOW)};
		end
	endfunction
	initial begin
		v = $urandom(32'h2BAE);
		cal_run(8'h55, 1'b1);
		cal_run(8'h56, 1'b0);
		cal_run(8'h50, 1'b0);
		strap(8'h59);
		count(1'b1);
		strap(8'h55);
		count(1'b0);
		for (e = 0; e < 3; e = e + 1)
			for (r = 0; r < 3; r = r + 1)
				for (c = 0; c < 3; c = c + 1)
					for (s = 0; s < 3; s = s + 1) begin
						strap({e[1:0], r[1:0], c[1:0], s[1:0]});
						x = exp_mode(s[1:0], c[1:0], r[1:0], e[1:0]);
						chk(mode_w, x[5:0]);
						if (EXT_CTRL_ACTIVE === 1'b0)
							chk(FULL_SCALE_SELECT, x[6]);
						chk(ALTERNATE_EXT_CTRL_ENABLE, !x[4] && s == 2 && e != 0);
						rd(`SPD_OFS_STATUS);
						chk(d[7:0], {e[1:0], r[1:0], c[1:0], s[1:0]});
						if (e == 0) begin
							v = $urandom;
							wr(`SPD_OFS_CTRL, v, 4'hF);
							repeat (3) @(negedge CORE_CLK);
							chk(FULL_SCALE_CODE, v[8:0]);
						end
					end
		v = $urandom;
		wr(`SPD_OFS_CTRL, v, 4'hF);
		wr(`SPD_OFS_CTRL, ~v, 4'h2);
		wr(`SPD_OFS_STATUS, v, 4'hF);
		chk(rsp, `SPD_RESP_OKAY);
		rd(`SPD_OFS_CTRL);
		chk(d, {23'h0, ~v[8], v[7:0]});
		rd(4'hC);
		chk({rsp, d[29:0]}, {`SPD_RESP_SLVERR, 30'h0});
		give_verdict;
	end
endmodule // testbench

// ==== verilog/spd_strap_decoder.v ====
// Strap pin mode decoder with AXI4-Lite status and full-scale adjust register
// Overview of operation
// - Shared pin selects range only when single-ended, pin-controlled
// - Shared pin low selects reduced input range
// - Shared pin high selects higher input range
// - Shared pin mid or floating enables extended control
// - Dedicated enable pin overrides shared-pin enable
// - Reset-select low makes shared pin reset negative
// - Differential reset mode forces higher range
// - Shared pin high/low: delay pin sets calibration delay
// - Shared pin floating: delay pin is serial chip select
// - Delay pin mid selects dual-edge I-only sampling
// - Sample on falling edge of input clock
// - Range from pin normally, register when extended
// - Dedicated enable low activates extended control
`timescale 1ns/1ps
module spd_strap_decoder #(
	parameter CAL_DLY_SHORT = 32'd4096,
	parameter CAL_DLY_LONG = 32'd65536
) (
	input wire CORE_CLK,
	input wire NRST,
	input wire SHARED_ABOVE_HI,
	input wire SHARED_BELOW_LO,
	input wire CAL_PIN_ABOVE_HI,
	input wire CAL_PIN_BELOW_LO,
	input wire RST_SEL_ABOVE_HI,
	input wire RST_SEL_BELOW_LO,
	input wire ECE_PIN_ABOVE_HI,
	input wire ECE_PIN_BELOW_LO,
	input wire SAMPLE_CLK_P,
	output reg FULL_SCALE_SELECT,
	output reg [8:0] FULL_SCALE_CODE,
	output reg EXT_CTRL_ACTIVE,
	output reg ALTERNATE_EXT_CTRL_ENABLE,
	output reg OUT_CLOCK_RESET_DIFF_SELECT,
	output reg OUT_CLOCK_RESET_NEG,
	output reg CAL_DELAY_SELECT,
	output reg SERIAL_CHIP_SELECT_N,
	output reg SERIAL_IF_ENABLE,
	output reg DUAL_EDGE_SAMPLING,
	output reg I_SAMPLE,
	output reg Q_SAMPLE,
	output reg CAL_START,
	input wire [3:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [3:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY
);
`include "spd_defs.vh"

	localparam ST_SETTLE = 3'h1;
	localparam ST_COUNT = 3'h2;
	localparam ST_DONE = 3'h4;

	// Floating or driven high counts as not-low on two-way-decoded pins
	function is_not_low;
		input [1:0] lvl;
		begin
			is_not_low = (lvl != `SPD_LVL_LOW);
		end
	endfunction
	function [31:0] byte_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			byte_merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					byte_merge[i * 8 +: 8] = new_val[i * 8 +: 8];
				end
			end
		end
	endfunction

	wire [1:0] shared_lvl;
	wire [1:0] cal_lvl;
	wire [1:0] rst_sel_lvl;
	wire [1:0] ece_lvl;

	spd_trilevel u_shared (
		.clk(CORE_CLK),
		.nrst(NRST),
		.above_hi(SHARED_ABOVE_HI),
		.below_lo(SHARED_BELOW_LO),
		.level_q(shared_lvl)
	);
	spd_trilevel u_cal (
		.clk(CORE_CLK),
		.nrst(NRST),
		.above_hi(CAL_PIN_ABOVE_HI),
		.below_lo(CAL_PIN_BELOW_LO),
		.level_q(cal_lvl)
	);
	spd_trilevel u_rst_sel (
		.clk(CORE_CLK),
		.nrst(NRST),
		.above_hi(RST_SEL_ABOVE_HI),
		.below_lo(RST_SEL_BELOW_LO),
		.level_q(rst_sel_lvl)
	);
	spd_trilevel u_ece (
		.clk(CORE_CLK),
		.nrst(NRST),
		.above_hi(ECE_PIN_ABOVE_HI),
		.below_lo(ECE_PIN_BELOW_LO),
		.level_q(ece_lvl)
	);

	reg [31:0] ctrl_q;
	reg clk_sync1_q;
	reg clk_sync2_q;
	reg clk_prev_q;
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [3:0] settle_q;
	reg [31:0] cal_cnt_q;
	reg [31:0] cal_cnt_d;
	reg cal_long_q;
	reg diff_rst_d;
	reg shared_role_d;
	reg ext_d;
	reg alt_ext_d;
	reg fs_high_d;
	reg [8:0] fs_code_d;
	reg ser_en_d;
	reg des_d;
	reg cal_dly_d;
	wire clk_fall = clk_prev_q && !clk_sync2_q;
	wire clk_rise = !clk_prev_q && clk_sync2_q;

	// Pin role resolution: reset-select first, then dedicated enable, then shared pin
	always @* begin
		diff_rst_d = !is_not_low(rst_sel_lvl);
		shared_role_d = !diff_rst_d && is_not_low(ece_lvl);
		alt_ext_d = shared_role_d && (shared_lvl == `SPD_LVL_MID);
		if (ece_lvl == `SPD_LVL_LOW) begin
			ext_d = 1'b1;
		end else if (ece_lvl == `SPD_LVL_HIGH) begin
			ext_d = 1'b0;
		end else begin
			ext_d = alt_ext_d;
		end
		if (diff_rst_d) begin
			fs_high_d = 1'b1;
		end else if (shared_lvl == `SPD_LVL_LOW) begin
			fs_high_d = 1'b0;
		end else begin
			fs_high_d = 1'b1;
		end
		if (ext_d) begin
			fs_code_d = ctrl_q[`SPD_CTRL_FS_ADJ_LSB +: `SPD_CTRL_FS_ADJ_W];
		end else if (fs_high_d) begin
			fs_code_d = `SPD_FS_CODE_HIGH;
		end else begin
			fs_code_d = `SPD_FS_CODE_LOW;
		end
		ser_en_d = (shared_lvl == `SPD_LVL_MID);
		// In serial use the delay pin carries no delay meaning
		cal_dly_d = !ser_en_d && (cal_lvl == `SPD_LVL_HIGH);
		des_d = (cal_lvl == `SPD_LVL_MID);
	end

	// Sampling clock arrives from a pin, so it is synchronised before edge detection
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			clk_sync1_q <= 1'b0;
			clk_sync2_q <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			clk_sync1_q <= SAMPLE_CLK_P;
			clk_sync2_q <= clk_sync1_q;
			clk_prev_q <= clk_sync2_q;
		end
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			FULL_SCALE_SELECT <= 1'b1;
			FULL_SCALE_CODE <= `SPD_FS_CODE_HIGH;
			EXT_CTRL_ACTIVE <= 1'b0;
			ALTERNATE_EXT_CTRL_ENABLE <= 1'b0;
			OUT_CLOCK_RESET_DIFF_SELECT <= 1'b0;
			OUT_CLOCK_RESET_NEG <= 1'b0;
			SERIAL_CHIP_SELECT_N <= 1'b1;
			SERIAL_IF_ENABLE <= 1'b0;
			DUAL_EDGE_SAMPLING <= 1'b0;
			I_SAMPLE <= 1'b0;
			Q_SAMPLE <= 1'b0;
		end else begin
			FULL_SCALE_SELECT <= fs_high_d;
			FULL_SCALE_CODE <= fs_code_d;
			EXT_CTRL_ACTIVE <= ext_d;
			ALTERNATE_EXT_CTRL_ENABLE <= alt_ext_d;
			OUT_CLOCK_RESET_DIFF_SELECT <= diff_rst_d;
			// Negative half of the reset pair; low when the pin has another role
			OUT_CLOCK_RESET_NEG <= diff_rst_d && (shared_lvl == `SPD_LVL_HIGH);
			SERIAL_IF_ENABLE <= ser_en_d;
			SERIAL_CHIP_SELECT_N <= !(ser_en_d && cal_lvl == `SPD_LVL_LOW);
			DUAL_EDGE_SAMPLING <= des_d;
			I_SAMPLE <= clk_fall || (des_d && clk_rise);
			Q_SAMPLE <= clk_fall && !des_d;
		end
	end

	// Power-up calibration delay: straps are taken once after they settle, not tracked later
	always @* begin
		state_d = state_q;
		cal_cnt_d = cal_cnt_q;
		case (state_q)
			ST_SETTLE: begin
				if (settle_q == `SPD_SETTLE_CYCLES) begin
					state_d = ST_COUNT;
					cal_cnt_d = cal_dly_d ? CAL_DLY_LONG : CAL_DLY_SHORT;
				end
			end
			ST_COUNT: begin
				if (cal_cnt_q == 32'h00000000) begin
					state_d = ST_DONE;
				end else if (clk_fall) begin
					cal_cnt_d = cal_cnt_q - 32'h00000001;
				end
			end
			ST_DONE: begin
				state_d = ST_DONE;
			end
			default: begin
				state_d = ST_SETTLE;
			end
		endcase
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= ST_SETTLE;
			settle_q <= 4'h0;
			cal_cnt_q <= 32'h00000000;
			cal_long_q <= 1'b0;
			CAL_DELAY_SELECT <= 1'b0;
			CAL_START <= 1'b0;
		end else begin
			state_q <= state_d;
			cal_cnt_q <= cal_cnt_d;
			CAL_START <= (state_q == ST_COUNT) && (state_d == ST_DONE);
			if (state_q == ST_SETTLE) begin
				settle_q <= settle_q + 4'h1;
				cal_long_q <= cal_dly_d;
				CAL_DELAY_SELECT <= cal_dly_d;
			end
		end
	end

	// AXI4-Lite slave: address and data are held separately so either may come first
	reg aw_held_q;
	reg w_held_q;
	reg [3:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [31:0] rdata_d;
	reg [1:0] rresp_d;
	reg [31:0] status_w;
	assign S_AXI_AWREADY = !aw_held_q && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held_q && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			ctrl_q <= `SPD_CTRL_RESET;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `SPD_RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			if (aw_held_q && w_held_q) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if ({aw_addr_q[3:2], 2'h0} == `SPD_OFS_CTRL) begin
					ctrl_q <= byte_merge(ctrl_q, w_data_q, w_strb_q) & 32'h000001FF;
					S_AXI_BRESP <= `SPD_RESP_OKAY;
				end else if ({aw_addr_q[3:2], 2'h0} == `SPD_OFS_STATUS || {aw_addr_q[3:2], 2'h0} == `SPD_OFS_CAL_CNT) begin
					// Read-only registers ignore the data but answer OKAY
					S_AXI_BRESP <= `SPD_RESP_OKAY;
				end else begin
					S_AXI_BRESP <= `SPD_RESP_SLVERR;
				end
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always @* begin
		status_w = 32'h00000000;
		status_w[`SPD_ST_SHARED_LSB +: 2] = shared_lvl;
		status_w[`SPD_ST_CALPIN_LSB +: 2] = cal_lvl;
		status_w[`SPD_ST_RSTSEL_LSB +: 2] = rst_sel_lvl;
		status_w[`SPD_ST_ECE_LSB +: 2] = ece_lvl;
		status_w[`SPD_ST_EXT_CTRL] = EXT_CTRL_ACTIVE;
		status_w[`SPD_ST_FS_HIGH] = FULL_SCALE_SELECT;
		status_w[`SPD_ST_DIFF_RST] = OUT_CLOCK_RESET_DIFF_SELECT;
		status_w[`SPD_ST_DUAL_EDGE] = DUAL_EDGE_SAMPLING;
		status_w[`SPD_ST_CAL_DLY] = cal_long_q;
		status_w[`SPD_ST_SER_EN] = SERIAL_IF_ENABLE;
		status_w[`SPD_ST_CAL_DONE] = (state_q == ST_DONE);
		rdata_d = 32'h00000000;
		rresp_d = `SPD_RESP_OKAY;
		case (S_AXI_ARADDR[3:2])
			2'h0: begin
				rdata_d = ctrl_q;
			end
			2'h1: begin
				rdata_d = status_w;
			end
			2'h2: begin
				rdata_d = cal_cnt_q;
			end
			default: begin
				rresp_d = `SPD_RESP_SLVERR;
			end
		endcase
	end

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= `SPD_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rdata_d;
				S_AXI_RRESP <= rresp_d;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end
endmodule // spd_strap_decoder

// ==== verilog/spd_trilevel.v ====
// Three-level strap input synchroniser and decoder
`timescale 1ns/1ps
module spd_trilevel (
	input wire clk,
	input wire nrst,
	input wire above_hi,
	input wire below_lo,
	output reg [1:0] level_q
);
`include "spd_defs.vh"

	reg [1:0] sync1_q;
	reg [1:0] sync2_q;
	reg [1:0] level_d;

	// Two flops before the comparator bits are looked at
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
		end else begin
			sync1_q <= {above_hi, below_lo};
			sync2_q <= sync1_q;
		end
	end

	// A floating pin rests at mid supply, so neither comparator trips
	always @* begin
		level_d = `SPD_LVL_MID;
		if (sync2_q[1] && !sync2_q[0]) begin
			level_d = `SPD_LVL_HIGH;
		end else if (sync2_q[0] && !sync2_q[1]) begin
			level_d = `SPD_LVL_LOW;
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			level_q <= `SPD_LVL_MID;
		end else begin
			level_q <= level_d;
		end
	end
endmodule // spd_trilevel
